/* File: shared/msq_pkg.sv */
// Purpose: constants and carrier types of the motor start sequencer
// Assumes: 250 MHz pclk, APB with 32-bit data
// Notes: frequencies in 0.01 Hz, times in 0.1 s, currents in percent
package msq_pkg;
  // ----------------------------------------------------------------
  // register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_MODE = 8'h04;
  localparam logic [7:0] OFS_FREQ = 8'h08;
  localparam logic [7:0] OFS_TIME = 8'h0C;
  localparam logic [7:0] OFS_CURR = 8'h10;
  localparam logic [7:0] OFS_RATE = 8'h14;
  localparam logic [7:0] OFS_MAXF = 8'h18;
  localparam logic [7:0] OFS_STAT = 8'h1C;
  // ----------------------------------------------------------------
  // field encodings, limits and reset values
  // ----------------------------------------------------------------
  localparam logic [1:0] METH_DIRECT = 2'h0;
  localparam logic [1:0] METH_TRACK = 2'h1;
  localparam logic [1:0] METH_PREX = 2'h2;
  localparam logic [1:0] ORG_STOP = 2'h0;
  localparam logic [1:0] ORG_ZERO = 2'h1;
  localparam logic [1:0] ORG_MAX = 2'h2;
  localparam logic [6:0] RATE_MIN = 7'h01;
  localparam logic [6:0] RATE_MAX = 7'h64;
  localparam logic [6:0] RATE_RST = 7'h14;
  localparam logic [9:0] START_F_MAX = 10'h3E8;
  localparam logic [9:0] TIME_MAX = 10'h3E8;
  localparam logic [6:0] PCT_MAX = 7'h64;
  localparam logic [15:0] MAXF_RST = 16'h1388;
  localparam logic [7:0] BASE_PCT = 8'h50;
  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 4;
  localparam int TENTH_S_NS = 100000000;
  localparam int TENTH_S_CYCLES = TENTH_S_NS / CLK_PERIOD_NS;
  // ----------------------------------------------------------------
  // sequencer states, gray in the order listed
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_STANDBY = 3'h0,
    ST_BRAKE = 3'h1,
    ST_PREX = 3'h3,
    ST_TRACK = 3'h2,
    ST_HOLD = 3'h6,
    ST_RAMP = 3'h7
  } msq_state_t;
  // ----------------------------------------------------------------
  // carriers to and from the power stage and ramp generator
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [15:0] run_freq;
    logic run_rev;
    logic [15:0] ramp_target;
    logic ramp_en;
    logic accel_time_en;
    logic program_time_en;
    logic dc_brake_en;
    logic preexc_en;
    logic [15:0] current_ref;
  } msq_drive_t;
  typedef struct packed {
    logic active;
    logic [15:0] seed_freq;
    logic [6:0] rate;
  } msq_trk_req_t;
  typedef struct packed {
    logic done;
    logic [15:0] freq;
    logic rev;
  } msq_trk_rsp_t;
endpackage

/* File: rtl/msq_sequencer.sv */
// Purpose: start-up sequencer of a motor drive with an APB register file
// Assumes: one clock, inputs synchronous to pclk, partner ramps speed
// Notes: drive currents are in the units of the rating register
//
// What this block does
// - method: 0 direct, 1 tracking, 2 pre-excite
// - direct, zero brake time: run at once
// - direct, nonzero brake time: brake first
// - tracking finds speed, direction, then runs
// - pre-excite, zero time: skip flux build
// - pre-excite, nonzero time: excite for interval
// - tracking origin: stop freq, zero, maximum
// - tracking rate 1 to 100, default 20
// - startup freq 0 to 10 Hz, ignores lower limit
// - target below startup freq: stay standby, zero
// - hold startup freq for hold time
// - direction reversal skips startup hold
// - hold not accel time, counts program time
// - start braking only for direct method or unused code 3
// - brake and pre-excite share current, time
// - current base: motor or 80% drive rating
`timescale 1ns/1ns
module msq_sequencer
  import msq_pkg::*;
#(
  parameter int TICK_CYCLES = TENTH_S_CYCLES
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire msq_trk_rsp_t trk_rsp,
  output msq_trk_req_t trk_req,
  output msq_drive_t drive
);
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    // software settings
    logic run_cmd;
    logic rev_cmd;
    logic [1:0] method;
    logic [1:0] origin;
    logic [6:0] rate;
    logic [9:0] start_f;
    logic [15:0] target_f;
    logic [9:0] hold_t;
    logic [9:0] brake_t;
    logic [6:0] pct;
    logic [15:0] motor_i;
    logic [15:0] drive_i;
    logic [15:0] max_f;
    // sequencer progress and interval timing
    msq_state_t st;
    logic [31:0] tick_cnt;
    logic [9:0] tenths;
    logic [15:0] stop_f;
    logic standby;
    // bus answer
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    // registered outputs toward the far side
    msq_trk_req_t trk;
    msq_drive_t drv;
  } msq_regs_t;

  msq_regs_t s_q;
  msq_regs_t s_d;
  // combinational helpers, all but base_i read by the next-state process
  logic [31:0] base_i;
  logic [31:0] cur_ref;
  logic setup;
  logic wr;
  logic tick;
  logic hit;
  logic low_target;
  logic reversing;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // current base: motor rating, or 80% of drive rating if motor is larger
  always_comb begin
    if (32'(s_q.motor_i) * 32'd100 <= 32'(s_q.drive_i) * 32'(BASE_PCT)) begin
      base_i = 32'(s_q.motor_i);
    end else begin
      base_i = 32'(s_q.drive_i) * 32'(BASE_PCT) / 32'd100;
    end
    // 16 by 7 bit products fit the 32-bit terms with room to spare
    // the divide truncates: a fraction of one current unit is lost
    cur_ref = base_i * 32'(s_q.pct) / 32'd100;
  end

  // ----------------------------------------------------------------
  // register map, one aligned 32-bit word each
  // ----------------------------------------------------------------
  // CTRL 0x00: [0] run, [1] reverse
  // MODE 0x04: [1:0] method, [3:2] search origin, [14:8] search rate
  // FREQ 0x08: [9:0] startup freq, [31:16] target freq, both 0.01 Hz
  // TIME 0x0C: [9:0] hold time, [25:16] brake or flux time, 0.1 s units
  // CURR 0x10: [6:0] brake or flux current, percent of the base
  // RATE 0x14: [15:0] motor rating, [31:16] drive rating, same units
  // MAXF 0x18: [15:0] maximum freq, seed of a search from the top
  // STAT 0x1C: [2:0] state, [4] held in standby, [31:16] output freq
  // settings out of range are clamped on write rather than refused,
  // so software never sees an error for a value it may simply retry
  // unmapped or unaligned words answer pslverr and read as zero;
  // writes there and to STAT are dropped without side effects
  // there are no byte strobes: a write always replaces the whole word

  // bus decode; the setup cycle prepares the answer for the access cycle
  assign setup = psel & ~penable;
  assign wr = psel & penable & pwrite & pready;
  assign tick = (s_q.tick_cnt == 32'(TICK_CYCLES - 1));
  assign hit = (paddr[1:0] == 2'h0) && (paddr <= OFS_STAT);
  // the startup freq is compared without any lower frequency limit
  assign low_target = (s_q.target_f < 16'(s_q.start_f));
  assign reversing = (s_q.rev_cmd != s_q.drv.run_rev);

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    // bus answer, one cycle after setup
    // zero wait states: pready stands for the first access cycle only
    s_d.pready = setup;
    s_d.pslverr = setup & ~hit;
    s_d.prdata = 32'h0;
    if (setup && !pwrite) begin
      case (paddr)
        OFS_CTRL: s_d.prdata = {30'h0, s_q.rev_cmd, s_q.run_cmd};
        OFS_MODE: s_d.prdata = {17'h0, s_q.rate, 4'h0, s_q.origin, s_q.method};
        OFS_FREQ: s_d.prdata = {s_q.target_f, 6'h0, s_q.start_f};
        OFS_TIME: s_d.prdata = {6'h0, s_q.brake_t, 6'h0, s_q.hold_t};
        OFS_CURR: s_d.prdata = {25'h0, s_q.pct};
        OFS_RATE: s_d.prdata = {s_q.drive_i, s_q.motor_i};
        OFS_MAXF: s_d.prdata = {16'h0, s_q.max_f};
        OFS_STAT: s_d.prdata = {s_q.drv.run_freq, 11'h0, s_q.standby, 1'b0, s_q.st};
        default: s_d.prdata = 32'h0;
      endcase
    end
    // register writes; out-of-range settings are clamped
    // a write lands at the edge that ends the access cycle
    if (wr) begin
      case (paddr)
        OFS_CTRL: begin
          s_d.run_cmd = pwdata[0];
          s_d.rev_cmd = pwdata[1];
        end
        OFS_MODE: begin
          s_d.method = pwdata[1:0];
          s_d.origin = pwdata[3:2];
          if (pwdata[14:8] < RATE_MIN) begin
            s_d.rate = RATE_MIN;
          end else if (pwdata[14:8] > RATE_MAX) begin
            s_d.rate = RATE_MAX;
          end else begin
            s_d.rate = pwdata[14:8];
          end
        end
        OFS_FREQ: begin
          s_d.start_f = (pwdata[9:0] > START_F_MAX) ? START_F_MAX : pwdata[9:0];
          s_d.target_f = pwdata[31:16];
        end
        OFS_TIME: begin
          s_d.hold_t = (pwdata[9:0] > TIME_MAX) ? TIME_MAX : pwdata[9:0];
          s_d.brake_t = (pwdata[25:16] > TIME_MAX) ? TIME_MAX : pwdata[25:16];
        end
        OFS_CURR: s_d.pct = (pwdata[6:0] > PCT_MAX) ? PCT_MAX : pwdata[6:0];
        OFS_RATE: begin
          s_d.motor_i = pwdata[15:0];
          s_d.drive_i = pwdata[31:16];
        end
        OFS_MAXF: s_d.max_f = pwdata[15:0];
        default: s_d.run_cmd = s_q.run_cmd;
      endcase
    end

    // 0.1 s prescaler and interval counter, restarted on entry to brake, flux build and hold
    // the prescaler only restarts in standby; leaving brake or flux build
    // on a tick wraps it to zero, so every interval is whole ticks long
    s_d.tick_cnt = tick ? 32'h0 : s_q.tick_cnt + 32'h1;
    if (tick) begin
      s_d.tenths = s_q.tenths + 10'h1;
    end
    s_d.trk.rate = s_q.rate;
    s_d.drv.current_ref = 16'(cur_ref);
    s_d.drv.ramp_target = s_q.target_f;

    // ----------------------------------------------------------------
    // sequencer
    // ----------------------------------------------------------------
    // usual paths, one state per step:
    //   direct or flux start with no interval: standby, hold, ramp
    //   with an interval: standby, brake or flux build, hold, ramp
    //   speed search: standby, search, ramp; the found speed needs no hold
    // a stop from any state returns to standby at once
    case (s_q.st)
      ST_STANDBY: begin
        s_d.drv.run_freq = 16'h0;
        s_d.drv.ramp_en = 1'b0;
        s_d.drv.accel_time_en = 1'b0;
        s_d.drv.program_time_en = 1'b0;
        s_d.drv.dc_brake_en = 1'b0;
        s_d.drv.preexc_en = 1'b0;
        s_d.trk.active = 1'b0;
        // standby is re-evaluated each cycle, so raising the target later
        // starts the motor without a new run command
        s_d.standby = s_q.run_cmd & low_target;
        s_d.tenths = 10'h0;
        s_d.tick_cnt = 32'h0;
        if (s_q.run_cmd && !low_target) begin
          s_d.standby = 1'b0;
          s_d.drv.run_rev = s_q.rev_cmd;
          case (s_q.method)
            METH_TRACK: begin
              s_d.st = ST_TRACK;
              s_d.trk.active = 1'b1;
              case (s_q.origin)
                ORG_ZERO: s_d.trk.seed_freq = 16'h0;
                ORG_MAX: s_d.trk.seed_freq = s_q.max_f;
                default: s_d.trk.seed_freq = s_q.stop_f;
              endcase
            end
            METH_PREX: begin
              if (s_q.brake_t == 10'h0) begin
                s_d.st = ST_HOLD;
                s_d.drv.run_freq = 16'(s_q.start_f);
                s_d.drv.program_time_en = 1'b1;
              end else begin
                s_d.st = ST_PREX;
                s_d.drv.preexc_en = 1'b1;
              end
            end
            default: begin
              // braking only reachable from the direct method and unused code 3
              if (s_q.brake_t == 10'h0) begin
                s_d.st = ST_HOLD;
                s_d.drv.run_freq = 16'(s_q.start_f);
                s_d.drv.program_time_en = 1'b1;
              end else begin
                s_d.st = ST_BRAKE;
                s_d.drv.dc_brake_en = 1'b1;
              end
            end
          endcase
        end
      end
      ST_BRAKE, ST_PREX: begin
        // same interval setting serves both, current_ref drives either
        // current_ref follows the settings live, even mid-interval
        if (tick && s_q.tenths + 10'h1 >= s_q.brake_t) begin
          s_d.st = ST_HOLD;
          s_d.tenths = 10'h0;
          s_d.drv.dc_brake_en = 1'b0;
          s_d.drv.preexc_en = 1'b0;
          s_d.drv.run_freq = 16'(s_q.start_f);
          s_d.drv.program_time_en = 1'b1;
        end
      end
      ST_TRACK: begin
        // the search partner's speed is trusted only with its done flag
        if (trk_rsp.done) begin
          s_d.trk.active = 1'b0;
          s_d.drv.run_freq = trk_rsp.freq;
          s_d.drv.run_rev = trk_rsp.rev;
          s_d.st = ST_RAMP;
          s_d.drv.ramp_en = 1'b1;
          s_d.drv.accel_time_en = 1'b1;
          s_d.drv.program_time_en = 1'b1;
        end
      end
      ST_HOLD: begin
        // held interval is program time but not acceleration time
        s_d.drv.accel_time_en = 1'b0;
        s_d.drv.program_time_en = 1'b1;
        if (reversing || s_q.hold_t == 10'h0 ||
            (tick && s_q.tenths + 10'h1 >= s_q.hold_t)) begin
          s_d.st = ST_RAMP;
          s_d.drv.run_rev = s_q.rev_cmd;
          s_d.drv.ramp_en = 1'b1;
          s_d.drv.accel_time_en = 1'b1;
        end
      end
      ST_RAMP: begin
        // a reversal re-enters at startup freq with no hold
        if (reversing) begin
          s_d.drv.run_rev = s_q.rev_cmd;
          s_d.drv.run_freq = 16'(s_q.start_f);
        end else begin
          s_d.drv.run_freq = s_q.target_f;
        end
      end
      default: s_d.st = ST_STANDBY;
    endcase

    // a stop drops everything; the last frequency seeds later tracking
    // output stops at once: any deceleration is the partner's job
    if (!s_q.run_cmd && s_q.st != ST_STANDBY) begin
      s_d.st = ST_STANDBY;
      s_d.stop_f = s_q.drv.run_freq;
      s_d.drv.run_freq = 16'h0;
      s_d.drv.ramp_en = 1'b0;
      s_d.drv.accel_time_en = 1'b0;
      s_d.drv.program_time_en = 1'b0;
      s_d.drv.dc_brake_en = 1'b0;
      s_d.drv.preexc_en = 1'b0;
      s_d.trk.active = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  // reset puts every setting at rest; rate, its trk_req copy and maximum freq are the
  // only fields that come up nonzero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '0;
      s_q.rate <= RATE_RST;
      s_q.max_f <= MAXF_RST;
      s_q.trk.rate <= RATE_RST;
      s_q.st <= ST_STANDBY;
    end else begin
      s_q <= s_d;
    end
  end

  // outputs straight from the state register
  // so no combinational path reaches a pin
  assign prdata = s_q.prdata;
  assign pready = s_q.pready;
  assign pslverr = s_q.pslverr;
  assign trk_req = s_q.trk;
  assign drive = s_q.drv;
endmodule // msq_sequencer

/* File: tb/msq_checker.sv */
// Purpose: port assertions for msq_sequencer
// Assumes: zero wait APB, all outputs registered
// Notes: bound at the foot of this file
`timescale 1ns/1ns
module msq_checker
  import msq_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire msq_trk_rsp_t trk_rsp,
  input wire msq_trk_req_t trk_req,
  input wire msq_drive_t drive
);
  // ----------------------------------------
  // properties, one clock domain
  // ----------------------------------------
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // answer comes in the first access cycle, once
  a_pready_setup: assert property (psel && !penable |=> pready)
    else $error("pready late");
  a_pready_single: assert property (pready |=> !pready)
    else $error("pready too long");
  a_brake_idle: assert property (
    drive.dc_brake_en |-> drive.run_freq == 16'h0 && !drive.preexc_en)
    else $error("output during brake");
  a_prex_idle: assert property (
    drive.preexc_en |-> drive.run_freq == 16'h0 && !drive.ramp_en)
    else $error("output during flux build");
  a_track_quiet: assert property (
    trk_req.active |-> drive.run_freq == 16'h0 && !drive.dc_brake_en)
    else $error("output during search");
  a_track_take: assert property (
    trk_req.active && trk_rsp.done |=> drive.run_freq == $past(trk_rsp.freq)
      && drive.run_rev == $past(trk_rsp.rev) && drive.ramp_en)
    else $error("tracked speed not used");
  a_hold_noaccel: assert property (
    drive.program_time_en && !drive.ramp_en |-> !drive.accel_time_en)
    else $error("hold counted as accel");
  a_ramp_count: assert property (
    drive.ramp_en |-> drive.program_time_en && drive.accel_time_en)
    else $error("ramp time flags wrong");
  a_rate_range: assert property (
    trk_req.rate >= RATE_MIN && trk_req.rate <= RATE_MAX)
    else $error("rate out of range");
endmodule // msq_checker
bind msq_sequencer msq_checker chk_u (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pready(pready), .trk_rsp(trk_rsp), .trk_req(trk_req), .drive(drive));

/* File: tb/msq_tracker.sv */
// Purpose: speed search partner of the sequencer
// Assumes: search runs while trk_req.active
// Notes: freq and rev carry garbage outside the done pulse
`timescale 1ns/1ns
module msq_tracker
  import msq_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire msq_trk_req_t trk_req,
  input wire logic [7:0] lag,
  input wire logic [15:0] found_f,
  input wire logic found_rev,
  output msq_trk_rsp_t trk_rsp
);
  logic [7:0] cnt_q;
  logic hit;
  assign hit = trk_req.active && cnt_q == lag;
  // search for lag cycles, then one done pulse; toggling data stops stale reuse
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= 8'h00;
      trk_rsp <= '0;
    end else begin
      trk_rsp.done <= hit;
      trk_rsp.freq <= hit ? found_f : ~trk_rsp.freq;
      trk_rsp.rev <= hit ? found_rev : ~trk_rsp.rev;
      cnt_q <= (trk_req.active && !hit) ? cnt_q + 8'h01 : 8'h00;
    end
  end
endmodule // msq_tracker

/* File: tb/testbench.sv */
// Purpose: self-checking bench of msq_sequencer
// Assumes: 8-cycle tick stands for 0.1 s
// Notes: register rows first, then start sequences
`timescale 1ns/1ns
module testbench
  import msq_pkg::*;
;
  typedef struct {logic [7:0] a; logic [31:0] d; logic [31:0] r; logic e;} msq_row_t;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd_q;
  logic pready, pslverr, err_q;
  logic [15:0] found_f = 16'h0;
  logic found_rev = 1'b0;
  msq_trk_rsp_t trk_rsp;
  msq_trk_req_t trk_req;
  msq_drive_t drive;
  int n_fail = 0;
  int checks_done = 0;
  int n;
  msq_row_t rows[7] = '{'{OFS_MODE, 32'h7F06, 32'h6406, 0}, '{OFS_MODE, 32'h1, 32'h101, 0},
    '{OFS_FREQ, 32'h0BB807FF, 32'h0BB803E8, 0}, '{OFS_TIME, 32'h03FF0005, 32'h03E80005, 0},
    '{OFS_CURR, 32'h7F, 32'h64, 0}, '{8'h20, 32'h5, 32'h0, 1}, '{8'h02, 32'h5, 32'h0, 1}};
  // ----------------------------------------
  // clock, instances, tasks
  // ----------------------------------------
  always #2 pclk = ~pclk;
  msq_sequencer #(.TICK_CYCLES(8)) dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .trk_rsp(trk_rsp), .trk_req(trk_req), .drive(drive));
  msq_tracker trk_u (.pclk(pclk), .presetn(presetn), .trk_req(trk_req), .lag(8'h05),
    .found_f(found_f), .found_rev(found_rev), .trk_rsp(trk_rsp));
  // one transfer; request held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // no fixed count: only the watchdog ends a wait for the answer
    do @(posedge pclk); while (pready !== 1'b1);
    rd_q = prdata;
    err_q = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      n_fail++;
      $display("wrong value %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // hang guard, far beyond the expected run
  initial begin
    #200000;
    n_fail++;
    final_report();
  end
  // main sequence
  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk("rate rst", 32'(RATE_RST), 32'(trk_req.rate));
    apb(0, OFS_MAXF, 0);
    chk("maxf", 32'h1388, rd_q);
    foreach (rows[i]) begin
      apb(1, rows[i].a, rows[i].d);
      apb(0, rows[i].a, 0);
      chk("reg", rows[i].r, rd_q);
      chk("err", 32'(rows[i].e), 32'(err_q));
    end
    $display("registers done");
    apb(1, OFS_MODE, 32'h1400);
    apb(1, OFS_FREQ, 32'h00C801F4);
    apb(1, OFS_TIME, 32'h0);
    apb(1, OFS_CTRL, 32'h1);
    repeat (30) @(posedge pclk);
    chk("standby f", 0, 32'(drive.run_freq));
    apb(0, OFS_STAT, 0);
    chk("standby", 1, 32'(rd_q[4]));
    apb(1, OFS_CTRL, 32'h0);
    apb(1, OFS_FREQ, 32'h03E801F4);
    apb(1, OFS_TIME, 32'h00020003);
    apb(1, OFS_CURR, 32'd50);
    apb(1, OFS_RATE, 32'h00C80064);
    apb(1, OFS_CTRL, 32'h1);
    repeat (2) @(posedge pclk);
    chk("brake", 1, 32'(drive.dc_brake_en));
    chk("i ref", 32'd50, 32'(drive.current_ref));
    n = 0;
    while (drive.run_freq === 16'h0 && n < 99) begin @(posedge pclk); n++; end
    chk("brake len", 1, 32'(n >= 12 && n <= 18));
    chk("start f", 32'd500, 32'(drive.run_freq));
    chk("hold acc", 0, 32'(drive.accel_time_en));
    chk("hold prog", 1, 32'(drive.program_time_en));
    n = 0;
    while (drive.ramp_en !== 1'b1 && n < 99) begin @(posedge pclk); n++; end
    chk("hold len", 1, 32'(n >= 20 && n <= 26));
    chk("target", 32'd1000, 32'(drive.ramp_target));
    apb(1, OFS_CTRL, 32'h0);
    @(posedge pclk);
    chk("stop f", 0, 32'(drive.run_freq));
    $display("direct brake done");
    for (int o = 0; o < 3; o++) begin
      found_f <= 16'(700 + o);
      found_rev <= o[0];
      apb(1, OFS_MODE, 32'h3201 | 32'(o << 2));
      apb(1, OFS_CTRL, 32'h1);
      @(posedge pclk);
      chk("trk on", 1, 32'(trk_req.active));
      chk("seed", o == 0 ? 1000 : o == 1 ? 0 : 32'h1388, 32'(trk_req.seed_freq));
      chk("rate", 32'h32, 32'(trk_req.rate));
      n = 0;
      while (drive.ramp_en !== 1'b1 && n < 99) begin @(posedge pclk); n++; end
      chk("trk f", 32'(700 + o), 32'(drive.run_freq));
      chk("trk rev", 32'(o[0]), 32'(drive.run_rev));
      repeat (2) @(posedge pclk);
      apb(1, OFS_CTRL, 32'h0);
    end
    $display("tracking done");
    apb(1, OFS_RATE, 32'h00C800BE);
    apb(1, OFS_TIME, 32'h00020000);
    apb(1, OFS_MODE, 32'h1402);
    apb(1, OFS_CTRL, 32'h1);
    repeat (2) @(posedge pclk);
    chk("prex", 1, 32'(drive.preexc_en));
    chk("no brake", 0, 32'(drive.dc_brake_en));
    chk("i base", 32'd80, 32'(drive.current_ref));
    apb(1, OFS_CTRL, 32'h0);
    apb(1, OFS_TIME, 32'h5);
    for (int m = 0; m < 3; m += 2) begin
      apb(1, OFS_MODE, 32'h1400 | 32'(m));
      apb(1, OFS_CTRL, 32'h1);
      repeat (2) @(posedge pclk);
      chk("skip", 0, 32'(drive.preexc_en | drive.dc_brake_en));
      chk("at once", 32'd500, 32'(drive.run_freq));
      apb(1, OFS_CTRL, 32'h3);
      repeat (2) @(posedge pclk);
      chk("rev ramp", 1, 32'(drive.ramp_en & drive.run_rev));
      apb(1, OFS_CTRL, 32'h0);
    end
    $display("start modes done");
    // reset in mid-run, while a zero-time pre-excite start holds its startup freq
    apb(1, OFS_CTRL, 32'h1);
    repeat (4) @(posedge pclk);
    chk("pre rst f", 32'd500, 32'(drive.run_freq));
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    chk("rst f", 0, 32'(drive.run_freq));
    chk("rst rate", 32'(RATE_RST), 32'(trk_req.rate));
    presetn <= 1'b1;
    @(posedge pclk);
    apb(0, OFS_CTRL, 0);
    chk("rst ctrl", 0, rd_q);
    apb(0, OFS_MODE, 0);
    chk("rst mode", {17'h0, RATE_RST, 8'h00}, rd_q);
    $display("reset done");
    final_report();
  end
endmodule // testbench
